// *** hw/supsv_pkg.sv ***
// constants, types and decode helpers of the supply supervisor control block
// assumes one 200 MHz clock and an AXI4-Lite master on the register side
// Summary of operation
// - A change of the level select field from zero to a nonzero code starts a settling delay of about 50 us before monitoring begins.
// - While that delay runs no low-voltage flag is set, no reset is requested and the monitor-active bit reads zero.
// - Any write to the control register during the delay ends it at once; monitoring then starts unless the write sets the level to zero.
// - A change from one nonzero level code to another inserts no delay.
// - Bits 7 to 4 select the level: zero turns the supervisor off, each nonzero code enables it, 1111 picks the external sense input.
// - With bit 3 set a latched low-voltage flag requests a power-on reset while monitoring is active; with it clear no reset is requested.
// - Bit 2 is a read-only monitor-active status; writing it never turns the supervisor on.
// - Bit 1 is read-only and shows the live comparator output.
// - Bit 0 latches a low-voltage condition until software clears it.
// - Control bits are cleared only by brownout reset, never by power-on reset or power-up clear.
// - Clearing the flag while the low-voltage condition persists sets it again at once.
// - After brownout reset the level select is zero, so the supervisor is off.
`default_nettype none
package supsv_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    // printed offset is not word aligned, so it is kept as an index
    localparam logic [ADDR_W-1:0] CTRL_INDEX = 12'h056;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_INDEX[9:0], 2'b00};
    localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 12'h15C;
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 12'h160;
    // control register layout
    localparam int LEVEL_HI = 7;
    localparam int LEVEL_LO = 4;
    localparam int RESET_EN_BIT = 3;
    localparam int ACTIVE_BIT = 2;
    localparam int COMP_BIT = 1;
    localparam int FLAG_BIT = 0;
    localparam logic [3:0] LEVEL_OFF = 4'h0;
    localparam logic [3:0] LEVEL_EXT = 4'hF;
    localparam logic [3:0] LEVEL_RESET = 4'h0;
    // interrupt layout
    localparam int IRQ_W = 2;
    localparam int IRQ_LOW_BIT = 0;
    localparam int IRQ_SETTLED_BIT = 1;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // settling time
    localparam int CLK_PERIOD_NS = 5;
    localparam int SETTLE_TIME_NS = 50000;
    localparam int SETTLE_CYCLES = SETTLE_TIME_NS / CLK_PERIOD_NS;
    localparam int SYNC_STAGES = 2;

    typedef enum logic {
        SETTLE_IDLE,
        SETTLE_RUN
    } supsv_settle_state_type;

    // a nonzero level code means the supervisor is powered
    function automatic logic supsv_level_on(input logic [3:0] level);
        supsv_level_on = (level != LEVEL_OFF);
    endfunction
endpackage
`default_nettype wire

// *** hw/supsv_settle_if.sv ***
// handshake between the register logic and the settling timer
// assumes both ends run on the same clock
`default_nettype none
interface supsv_settle_if;
    logic start;
    logic abort;
    logic busy;
    logic done;
    modport ctrl (output start, output abort, input busy, input done);
    modport timer (input start, input abort, output busy, output done);
endinterface
`default_nettype wire

// *** hw/supsv_settle.sv ***
// settling delay timer of the supply supervisor
// assumes start only while idle; abort ends a running delay at once
`default_nettype none
module supsv_settle
    import supsv_pkg::*;
#(
    parameter int unsigned COUNT = SETTLE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    supsv_settle_if.timer tmr
);
    supsv_settle_state_type state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] load_value;
    logic expire;

    assign load_value = CNT_W'(COUNT - 1);
    assign expire = (state == SETTLE_RUN) && (cnt == '0);
    assign tmr.busy = (state == SETTLE_RUN);
    assign tmr.done = expire && !tmr.abort;

    // down counter on the device clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= SETTLE_IDLE;
            cnt <= '0;
        end else begin
            case (state)
                SETTLE_IDLE: begin
                    if (tmr.start) begin
                        state <= SETTLE_RUN;
                        cnt <= load_value;
                    end
                end
                SETTLE_RUN: begin
                    if (tmr.abort || expire) begin
                        state <= SETTLE_IDLE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                default: state <= SETTLE_IDLE;
            endcase
        end
    end

    // busy cycles of the current run, read only by the length check
    logic [CNT_W-1:0] run_len;

    always_ff @(posedge aclk) begin
        if (!aresetn || !tmr.busy) begin
            run_len <= '0;
        end else begin
            run_len <= run_len + 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_abort_stops: assert property (tmr.busy && tmr.abort |=> !tmr.busy)
        else $error("settling delay kept running after abort");
    a_delay_length: assert property (
        tmr.done |-> run_len == CNT_W'(COUNT - 1))
        else $error("settling delay length wrong");
endmodule
`default_nettype wire

// *** hw/supsv_top.sv ***
// supply supervisor control: register, settling delay, flag and reset request
// assumes an AXI4-Lite master on aclk and an asynchronous comparator pin
//
// The AXI4-Lite interface to the registers is this design's own decision.
`default_nettype none
module supsv_top
    import supsv_pkg::*;
#(
    parameter int unsigned SETTLE_COUNT = SETTLE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [supsv_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [supsv_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [supsv_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [supsv_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // analog side
    input wire logic comparator_output,
    input wire logic power_up_clear,
    output logic [3:0] level_select,
    output logic external_sense_input,
    output logic supervisor_enable,
    output logic monitor_active,
    output logic power_on_reset_request,
    output logic irq
);
    supsv_settle_if settle_link ();

    // control register state; aresetn is the brownout reset
    logic [3:0] level;
    logic reset_on_low_enable;
    logic low_voltage_flag;
    // comparator synchroniser
    logic comp_meta;
    logic comp_sync;
    // interrupt registers
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    // write channel holding
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;

    // decode
    logic do_write;
    logic ctrl_hit;
    logic ctrl_wr;
    logic stat_wr;
    logic mask_wr;
    logic wr_mapped;
    logic [3:0] wr_level;
    logic [3:0] next_level;
    logic next_flag;
    logic flag_set;
    logic settle_start;
    logic settle_abort;
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] next_irq_status;
    logic [IRQ_W-1:0] next_irq_mask;
    logic [7:0] ctrl_view;
    logic read_take;
    logic rd_mapped;
    logic [DATA_W-1:0] next_rdata;

    supsv_settle #(
        .COUNT(SETTLE_COUNT)
    ) u_settle (
        .aclk(aclk),
        .aresetn(aresetn),
        .tmr(settle_link.timer)
    );

    // the pin is asynchronous, only the second stage is looked at
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            comp_meta <= 1'b0;
            comp_sync <= 1'b0;
        end else begin
            comp_meta <= comparator_output;
            comp_sync <= comp_meta;
        end
    end

    // write decode; both channels must be held before the write acts
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign ctrl_hit = do_write && (aw_addr == CTRL_ADDR);
    assign ctrl_wr = ctrl_hit && w_strb[0];
    assign stat_wr = do_write && (aw_addr == IRQ_STAT_ADDR) && w_strb[0];
    assign mask_wr = do_write && (aw_addr == IRQ_MASK_ADDR) && w_strb[0];
    assign wr_mapped = (aw_addr == CTRL_ADDR) || (aw_addr == IRQ_STAT_ADDR)
        || (aw_addr == IRQ_MASK_ADDR);
    assign wr_level = w_data[LEVEL_HI:LEVEL_LO];
    assign next_level = ctrl_wr ? wr_level : level;

    // the delay starts only on a zero to nonzero change
    assign settle_start = ctrl_wr && !supsv_level_on(level)
        && supsv_level_on(wr_level) && !settle_link.busy;
    // any control write, even with its lane off, cuts the delay short
    assign settle_abort = ctrl_hit && settle_link.busy;
    assign settle_link.start = settle_start;
    assign settle_link.abort = settle_abort;

    // status bit is derived, never stored, so a write cannot set it
    assign monitor_active = supsv_level_on(level) && !settle_link.busy;

    // comparator high means the supply is below threshold
    assign flag_set = monitor_active && comp_sync;
    // set wins over a software clear, so a lasting condition re-flags
    assign next_flag = flag_set
        || (ctrl_wr ? w_data[FLAG_BIT] : low_voltage_flag);

    // control register; only the brownout reset clears it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level <= LEVEL_RESET;
            reset_on_low_enable <= 1'b0;
            low_voltage_flag <= 1'b0;
        end else begin
            level <= next_level;
            low_voltage_flag <= next_flag;
            if (ctrl_wr) begin
                reset_on_low_enable <= w_data[RESET_EN_BIT];
            end
        end
    end

    // analog drive and reset request, registered so they stay glitch free
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_select <= LEVEL_RESET;
            external_sense_input <= 1'b0;
            supervisor_enable <= 1'b0;
            power_on_reset_request <= 1'b0;
        end else begin
            level_select <= next_level;
            external_sense_input <= (next_level == LEVEL_EXT);
            supervisor_enable <= supsv_level_on(next_level);
            power_on_reset_request <= reset_on_low_enable
                && low_voltage_flag && monitor_active;
        end
    end

    // interrupt events: fresh low-voltage flag and natural end of settling
    assign irq_event[IRQ_LOW_BIT] = flag_set && !low_voltage_flag;
    assign irq_event[IRQ_SETTLED_BIT] = settle_link.done;
    // write one to clear, an event in the same cycle wins
    assign next_irq_status = irq_event
        | (irq_status & ~(stat_wr ? w_data[IRQ_W-1:0] : IRQ_RESET));
    // power-up clear masks interrupts but leaves the control bits alone
    assign next_irq_mask = power_up_clear ? IRQ_RESET
        : (mask_wr ? w_data[IRQ_W-1:0] : irq_mask);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= IRQ_RESET;
            irq_mask <= IRQ_RESET;
            irq <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            irq <= |(irq_status & irq_mask);
        end
    end

    // write channels accepted in either order, one response at a time
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    // write response; unmapped addresses answer with a slave error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read view of the control register, bits above the byte read zero
    assign ctrl_view = {level, reset_on_low_enable, monitor_active,
        comp_sync, low_voltage_flag};
    assign read_take = s_axi_arvalid && s_axi_arready;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_mapped = (s_axi_araddr == CTRL_ADDR)
        || (s_axi_araddr == IRQ_STAT_ADDR) || (s_axi_araddr == IRQ_MASK_ADDR);
    assign next_rdata = (s_axi_araddr == CTRL_ADDR) ? DATA_W'(ctrl_view)
        : (s_axi_araddr == IRQ_STAT_ADDR) ? DATA_W'(irq_status)
        : (s_axi_araddr == IRQ_MASK_ADDR) ? DATA_W'(irq_mask)
        : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (read_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // settling delay: start, silence, abort and natural end
    a_settle_begins: assert property (
        settle_start |=> settle_link.busy && !monitor_active)
        else $error("settling delay did not start");

    a_quiet_settle: assert property (
        settle_link.busy
        |=> !power_on_reset_request && !$rose(low_voltage_flag))
        else $error("flag or reset during settling delay");

    a_abort_active: assert property (
        settle_abort && supsv_level_on(wr_level) |=> monitor_active)
        else $error("write did not end the settling delay");

    a_level_swap: assert property (
        ctrl_wr && !settle_link.busy && supsv_level_on(level)
        && supsv_level_on(wr_level) |=> monitor_active)
        else $error("delay inserted between nonzero levels");

    a_settled_active: assert property (
        settle_link.done |=> monitor_active)
        else $error("monitoring not active after the delay");

    a_settle_irq: assert property (
        settle_link.done |=> irq_status[IRQ_SETTLED_BIT])
        else $error("end of settling delay not reported");

    // level select drive toward the analog side
    a_ext_select: assert property (
        ctrl_wr |=> ##1
        external_sense_input == ($past(wr_level, 2) == LEVEL_EXT))
        else $error("external sense select wrong");

    a_level_follow: assert property (
        ctrl_wr |=> level_select == $past(wr_level))
        else $error("level select output does not follow write");

    a_enable_follow: assert property (
        ctrl_wr |=> supervisor_enable == ($past(wr_level) != LEVEL_OFF))
        else $error("supervisor enable does not follow level");

    a_write_no_on: assert property (
        ctrl_wr && !supsv_level_on(wr_level) |=> !monitor_active [*2])
        else $error("supervisor on with zero level");

    a_active_powered: assert property (
        monitor_active |-> supervisor_enable)
        else $error("monitoring reported while supervisor off");

    // flag, reset request and control bit retention
    a_reset_gate: assert property (
        power_on_reset_request
        |-> $past(reset_on_low_enable) && $past(low_voltage_flag))
        else $error("reset request without enable and flag");

    a_por_raise: assert property (
        reset_on_low_enable && low_voltage_flag && monitor_active
        |=> power_on_reset_request)
        else $error("flag with reset enabled did not request reset");

    a_por_gate_off: assert property (
        !reset_on_low_enable |=> !power_on_reset_request)
        else $error("reset requested while disabled");

    a_comp_view: assert property (
        ##2 comp_sync == $past(comparator_output, 2))
        else $error("comparator status not live");

    a_flag_latch: assert property (
        low_voltage_flag && !ctrl_wr |=> low_voltage_flag)
        else $error("flag dropped without software clear");

    a_flag_clear: assert property (
        ctrl_wr && !w_data[FLAG_BIT] && !flag_set |=> !low_voltage_flag)
        else $error("software clear of the flag ignored");

    a_low_irq: assert property (
        flag_set && !low_voltage_flag |=> irq_status[IRQ_LOW_BIT])
        else $error("new low-voltage flag not reported");

    a_flag_reset: assert property (
        flag_set |=> low_voltage_flag)
        else $error("persisting condition not re-flagged");

    a_keep_on_clear: assert property (
        power_up_clear && !ctrl_wr
        |=> $stable(level) && $stable(reset_on_low_enable))
        else $error("power-up clear changed control bits");

    a_level_hold: assert property (
        !ctrl_wr |=> $stable(level))
        else $error("level changed without a control write");
endmodule
`default_nettype wire

// *** verification/supsv_analog_model.sv ***
// behavioural comparator and device reset logic facing the supervisor
// assumes the bench sets the supply and sense conditions on aclk
`default_nettype none
module supsv_analog_model (
    input wire logic aclk,
    input wire logic supply_low,
    input wire logic sense_low,
    input wire logic [3:0] level_select,
    input wire logic supervisor_enable,
    input wire logic power_on_reset_request,
    output logic comparator_output,
    output var int por_count
);
    timeunit 1ns;
    timeprecision 100ps;
    logic req_q = 1'b0;
    // an unpowered comparator cannot see a low supply, so it stays low
    assign comparator_output = supervisor_enable &&
        ((level_select == 4'hF) ? sense_low : supply_low);
    // each new request counts as one device reset
    initial por_count = 0;
    always @(posedge aclk) begin
        req_q <= power_on_reset_request;
        if (power_on_reset_request && !req_q) begin
            por_count <= por_count + 1;
        end
    end
endmodule
`default_nettype wire

// *** verification/test_supply_supervisor_control.sv ***
// self-checking bench of the supply supervisor control block
// assumes a short settling count; registers reached over axi4-lite
`default_nettype none
module test_supply_supervisor_control;
    timeunit 1ns;
    timeprecision 100ps;
    import supsv_pkg::*;
    localparam int SC = 8;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata;
    logic [3:0] wstrb = 4'hF, level_select;
    // response channels stay ready, so no answer is ever held back
    logic awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic comparator_output, power_up_clear = 0, external_sense_input;
    logic supervisor_enable, monitor_active, power_on_reset_request, irq;
    logic supply_low = 0, sense_low = 0;
    int por_count, err_total = 0, n_tests = 0;

    always #2.5 aclk = ~aclk;

    supsv_top #(.SETTLE_COUNT(SC)) i_supsv_top (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .comparator_output(comparator_output),
        .power_up_clear(power_up_clear), .level_select(level_select),
        .external_sense_input(external_sense_input),
        .supervisor_enable(supervisor_enable),
        .monitor_active(monitor_active),
        .power_on_reset_request(power_on_reset_request), .irq(irq)
    );

    supsv_analog_model i_supsv_analog_model (
        .aclk(aclk), .supply_low(supply_low), .sense_low(sense_low),
        .level_select(level_select), .supervisor_enable(supervisor_enable),
        .power_on_reset_request(power_on_reset_request),
        .comparator_output(comparator_output), .por_count(por_count)
    );

    task automatic stop_test();
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // expected control byte from level, reset enable and status bits
    function automatic logic [31:0] ctl(input logic [3:0] lv,
                                        input logic [3:0] low);
        return {24'h0, lv, low};
    endfunction

    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask

    // both channels offered together; each dropped once it is taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (n < 50) begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        check("bvalid", 32'(bvalid), 1);
        check("bresp", 32'(bresp), 32'(er));
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic [1:0] er = RESP_OKAY);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        while (n < 50) begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        check("rvalid", 32'(rvalid), 1);
        check("rresp", 32'(rresp), 32'(er));
        check("rdata", rdata, e);
    endtask

    // a hang costs far more than the whole sequence should take
    initial begin
        #200us;
        err_total++;
        stop_test();
    end

    initial begin
        int k, p;
        logic [3:0] lv;
        k = $urandom(32'hBD6B36D9);
        cyc(2);
        aresetn <= 1'b1;
        rd(CTRL_ADDR, 32'h0);
        rd(12'h200, 32'h0, RESP_SLVERR);
        wr(12'h200, 32'hFF, RESP_SLVERR);
        wr(IRQ_MASK_ADDR, 32'h3);
        // low supply during the delay must stay unseen
        supply_low <= 1'b1;
        wr(CTRL_ADDR, 32'h88);
        for (k = 0; k < 4; k++) begin
            cyc(1);
            check("active", 32'(monitor_active), 0);
            check("por", 32'(power_on_reset_request), 0);
        end
        while (monitor_active !== 1'b1 && k < 100) begin
            cyc(1);
            k++;
        end
        check("delay", 32'(k >= SC - 2 && k <= SC + 2), 1);
        cyc(5);
        rd(CTRL_ADDR, ctl(4'h8, 4'hF));
        check("resets", por_count, 1);
        // clearing while still low sets the flag again
        wr(CTRL_ADDR, 32'h88);
        cyc(3);
        rd(CTRL_ADDR, ctl(4'h8, 4'hF));
        // let the recovery pass the synchroniser first, or the flag re-sets
        supply_low <= 1'b0;
        cyc(4);
        wr(CTRL_ADDR, 32'h80);
        cyc(5);
        p = por_count;
        rd(CTRL_ADDR, ctl(4'h8, 4'h4));
        supply_low <= 1'b1;
        cyc(6);
        rd(CTRL_ADDR, ctl(4'h8, 4'h7));
        check("no reset", por_count, p);
        supply_low <= 1'b0;
        cyc(4);
        rd(CTRL_ADDR, ctl(4'h8, 4'h5));
        // interrupt raised, masked, unmasked and cleared
        rd(IRQ_STAT_ADDR, 32'h3);
        wr(IRQ_MASK_ADDR, 32'h0);
        cyc(2);
        check("irq off", 32'(irq), 0);
        wr(IRQ_MASK_ADDR, 32'h3);
        cyc(2);
        check("irq on", 32'(irq), 1);
        wr(IRQ_STAT_ADDR, 32'h3);
        cyc(2);
        check("irq clr", 32'(irq), 0);
        rd(IRQ_STAT_ADDR, 32'h0);
        power_up_clear <= 1'b1;
        cyc(1);
        power_up_clear <= 1'b0;
        rd(CTRL_ADDR, ctl(4'h8, 4'h5));
        rd(IRQ_MASK_ADDR, 32'h0);
        // level to level change keeps monitoring at once
        wr(CTRL_ADDR, 32'hF0);
        cyc(1);
        check("active", 32'(monitor_active), 1);
        check("ext", 32'(external_sense_input), 1);
        sense_low <= 1'b1;
        cyc(5);
        rd(CTRL_ADDR, ctl(4'hF, 4'h7));
        sense_low <= 1'b0;
        // a write from level zero to level 1 starts the delay, monitoring stays off
        wr(CTRL_ADDR, 32'h0);
        wr(CTRL_ADDR, 32'h10);
        cyc(1);
        check("busy", 32'(monitor_active), 0);
        // lane 0 off: nothing is stored, yet the delay still ends
        wstrb <= 4'h0;
        wr(CTRL_ADDR, 32'h10);
        wstrb <= 4'hF;
        cyc(1);
        check("abort", 32'(monitor_active), 1);
        wr(CTRL_ADDR, 32'h0);
        wr(CTRL_ADDR, 32'h04);
        cyc(SC + 4);
        check("on bit", 32'(monitor_active), 0);
        check("enable", 32'(supervisor_enable), 0);
        rd(CTRL_ADDR, 32'h0);
        // random levels, each entered through level zero
        repeat (6) begin
            lv = 4'($urandom_range(1, 15));
            wr(CTRL_ADDR, 32'h0);
            wr(CTRL_ADDR, ctl(lv, 4'h0));
            cyc(SC + 4);
            rd(CTRL_ADDR, ctl(lv, 4'h4));
            check("level", 32'(level_select), 32'(lv));
            check("ext", 32'(external_sense_input), 32'(lv == 4'hF));
        end
        // brownout while monitoring at level 9, with no delay running, clears the register
        wr(CTRL_ADDR, 32'h98);
        aresetn <= 1'b0;
        cyc(2);
        aresetn <= 1'b1;
        rd(CTRL_ADDR, 32'h0);
        check("enable", 32'(supervisor_enable), 0);
        stop_test();
    end
endmodule
`default_nettype wire
